// [core/ubm_core.sv]
// serial port with baud/configuration word, match logic and framing
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ubm_core (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic [ubm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ubm_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [ubm_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                        rx_pin,
  input  wire logic                        cts_n_pin,
  output logic                             tx_pin,
  output logic                             irq
);
  import ubm_pkg::*;

  // configuration and software-visible state
  logic              men1_q, men1_d, men2_q, men2_d, ten_q, ten_d;
  logic [4:0]        osr_q, osr_d;
  ubm_scheme_t       sch_q, sch_d;
  logic              dual_q, dual_d;
  logic [MOD_W-1:0]  mod_q, mod_d;
  logic [CHAR_W-1:0] mv1_q, mv1_d, mv2_q, mv2_d, txh_q, txh_d;
  logic [CHAR_W-1:0] rxd_q, rxd_d;
  logic              txen_q, txen_d, rxen_q, rxen_d, nine_q, nine_d;
  logic              txh_full_q, txh_full_d;
  logic [ST_W-1:0]   stat_q, stat_d, mask_q, mask_d, ev;
  logic [DATA_W-1:0] rd_q, rd_d, cfg_word;
  logic [4:0]        osr_wr;
  // pin synchronisers, three stages each
  logic [2:0]        rxs_q, ctss_q;
  logic              rx_lvl_q, rx_lvl_d, cts_n_q, cts_n_d;
  // receiver
  ubm_rx_t           rst_q, rst_d;
  logic [SMP_W-1:0]  smp_q, smp_d, tpb_rx, tpb_tx;
  logic [3:0]        bit_q, bit_d, clen;
  logic [CHAR_W-1:0] rsh_q, rsh_d, rchar;
  logic              idle_seen_q, idle_seen_d, act_q, act_d;
  logic              rx_done, hit1, hit2, any_en, mark, deliver, st;
  // transmitter
  logic              tbusy_q, tbusy_d, cts_ok, tx_start, tx_done;
  logic [11:0]       tsh_q, tsh_d;
  logic [SMP_W-1:0]  tsmp_q, tsmp_d;
  logic [3:0]        tbit_q, tbit_d;

  ubm_tick_if tk ();
  assign tk.modulo = mod_q;
  assign tk.dual   = dual_q;

  ubm_baud_div u_div (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tk      (tk)
  );

  // character length and per-bit sample counts
  always_comb begin
    clen   = ten_q ? LEN10 : (nine_q ? LEN9 : LEN8);
    tpb_tx = 7'(osr_q) + 7'h01;
    tpb_rx = tpb_tx << dual_q;
    st     = tk.tick || tk.half_tick;
    osr_wr = wr_data[OSR_HI:OSR_LO];
    cfg_word = '0;
    cfg_word[B_MEN1] = men1_q;
    cfg_word[B_MEN2] = men2_q;
    cfg_word[B_TEN]  = ten_q;
    cfg_word[OSR_HI:OSR_LO] = osr_q;
    cfg_word[SCH_HI:SCH_LO] = sch_q;
    cfg_word[B_DUAL] = dual_q;
    cfg_word[MOD_HI:0] = mod_q;
  end

  // register writes, reads and sticky status
  always_comb begin
    men1_d = men1_q; men2_d = men2_q; ten_d = ten_q; osr_d = osr_q;
    sch_d = sch_q; dual_d = dual_q; mod_d = mod_q;
    mv1_d = mv1_q; mv2_d = mv2_q; mask_d = mask_q;
    txen_d = txen_q; rxen_d = rxen_q; nine_d = nine_q;
    txh_d = txh_q;
    txh_full_d = txh_full_q && !tx_start;
    stat_d = stat_q;
    rd_d = '0;
    if (wr_en) begin
      case (addr)
        OFF_CFG: begin
          men1_d = wr_data[B_MEN1];
          men2_d = wr_data[B_MEN2];
          ten_d  = wr_data[B_TEN];
          osr_d  = (osr_wr < OSR_MIN) ? OSR_DEF : osr_wr;
          sch_d  = ubm_scheme_t'(wr_data[SCH_HI:SCH_LO]);
          dual_d = wr_data[B_DUAL];
          mod_d  = wr_data[MOD_HI:0];
        end
        OFF_MATCH: begin
          mv1_d = wr_data[MV1_LO +: CHAR_W];
          mv2_d = wr_data[MV2_LO +: CHAR_W];
        end
        OFF_CTRL: begin
          txen_d = wr_data[C_TXEN];
          rxen_d = wr_data[C_RXEN];
          nine_d = wr_data[C_NINE];
        end
        OFF_DATA: begin
          if (!txh_full_q) begin
            txh_d      = wr_data[CHAR_W-1:0];
            txh_full_d = 1'b1;
          end
        end
        OFF_STAT: stat_d = stat_q & ~wr_data[ST_W-1:0];
        OFF_MASK: mask_d = wr_data[ST_W-1:0];
        default: ;
      endcase
    end
    stat_d = stat_d | ev;                                   // set wins
    if (rd_en) begin
      case (addr)
        OFF_CFG:   rd_d = cfg_word;
        OFF_MATCH: rd_d = {6'h00, mv2_q, 6'h00, mv1_q};
        OFF_CTRL:  rd_d = {29'h0, nine_q, rxen_q, txen_q};
        OFF_DATA:  rd_d = {22'h0, rxd_q};
        OFF_STAT:  rd_d = {26'h0, stat_q};
        OFF_MASK:  rd_d = {26'h0, mask_q};
        default:   rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      men1_q <= 1'b0; men2_q <= 1'b0; ten_q <= 1'b0; osr_q <= OSR_DEF;
      sch_q <= SCH_ADDR; dual_q <= 1'b0; mod_q <= MOD_RST;
      mv1_q <= '0; mv2_q <= '0; mask_q <= '0; stat_q <= '0;
      txen_q <= 1'b0; rxen_q <= 1'b0; nine_q <= 1'b0;
      txh_q <= '0; txh_full_q <= 1'b0; rd_q <= '0;
    end else begin
      men1_q <= men1_d; men2_q <= men2_d; ten_q <= ten_d; osr_q <= osr_d;
      sch_q <= sch_d; dual_q <= dual_d; mod_q <= mod_d;
      mv1_q <= mv1_d; mv2_q <= mv2_d; mask_q <= mask_d; stat_q <= stat_d;
      txen_q <= txen_d; rxen_q <= rxen_d; nine_q <= nine_d;
      txh_q <= txh_d; txh_full_q <= txh_full_d; rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign irq     = |(stat_q & mask_q);

  // pin synchronisers; a level counts once stages two and three agree
  always_comb begin
    rx_lvl_d = (rxs_q[1] == rxs_q[2]) ? rxs_q[2] : rx_lvl_q;
    cts_n_d  = (ctss_q[1] == ctss_q[2]) ? ctss_q[2] : cts_n_q;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxs_q <= 3'h7; ctss_q <= 3'h7; rx_lvl_q <= 1'b1; cts_n_q <= 1'b1;
    end else begin
      rxs_q <= {rxs_q[1:0], rx_pin};
      ctss_q <= {ctss_q[1:0], cts_n_pin};
      rx_lvl_q <= rx_lvl_d;
      cts_n_q <= cts_n_d;
    end
  end

  // receive framing, idle detection and match filtering
  always_comb begin
    rst_d = rst_q; smp_d = smp_q; bit_d = bit_q; rsh_d = rsh_q;
    idle_seen_d = idle_seen_q; act_d = act_q; rxd_d = rxd_q;
    rx_done = 1'b0;
    ev = '0;
    case (clen)
      LEN10:   rchar = rsh_q;
      LEN9:    rchar = {1'b0, rsh_q[CHAR_W-1:1]};
      default: rchar = {2'b00, rsh_q[CHAR_W-1:2]};
    endcase
    mark   = rchar[clen - 4'h1];
    any_en = men1_q || men2_q;
    hit1   = men1_q && (rchar == mv1_q);
    hit2   = men2_q && (rchar == mv2_q);
    if (!rxen_q) begin
      rst_d = RX_IDLE; smp_d = '0; bit_d = '0;
    end else if (st) begin
      case (rst_q)
        RX_IDLE: begin
          if (!rx_lvl_q) begin
            rst_d = RX_START; smp_d = '0;
          end else if (smp_q == tpb_rx - 7'h01) begin
            smp_d = '0;
            bit_d = bit_q + 4'h1;
            if (bit_q == clen + IDLE_EX) begin
              idle_seen_d = 1'b1;
              ev[S_IDLE]  = !idle_seen_q;
            end
          end else smp_d = smp_q + 7'h01;
        end
        RX_START: begin
          if (smp_q == (tpb_rx >> 1) - 7'h01) begin
            rst_d = rx_lvl_q ? RX_IDLE : RX_DATA;
            smp_d = '0; bit_d = '0;
          end else smp_d = smp_q + 7'h01;
        end
        RX_DATA: begin
          if (smp_q == tpb_rx - 7'h01) begin
            rsh_d = {rx_lvl_q, rsh_q[CHAR_W-1:1]};
            smp_d = '0;
            bit_d = bit_q + 4'h1;
            if (bit_q == clen - 4'h1) rst_d = RX_STOP;
          end else smp_d = smp_q + 7'h01;
        end
        RX_STOP: begin
          if (smp_q == tpb_rx - 7'h01) begin
            rx_done = 1'b1;
            ev[S_FERR] = !rx_lvl_q;
            rst_d = RX_IDLE; smp_d = '0; bit_d = '0;
          end else smp_d = smp_q + 7'h01;
        end
        default: rst_d = RX_IDLE;
      endcase
    end
    if (rx_done) begin
      case (sch_q)
        SCH_ADDR: if (any_en && mark) act_d = hit1 || hit2;
        SCH_IDLE: if (any_en && idle_seen_q) act_d = hit1 || hit2;
        default: begin
          if (hit1) act_d = 1'b1;
          if (hit2) act_d = 1'b0;
        end
      endcase
      if (sch_q == SCH_CTS && (hit1 || hit2)) act_d = act_d || hit1;
      idle_seen_d = 1'b0;
      deliver = !any_en || act_d || act_q;
      ev[S_M1] = hit1;
      ev[S_M2] = hit2;
      ev[S_RXF] = deliver;
      if (deliver) rxd_d = rchar;
    end else deliver = 1'b0;
    ev[S_TXE] = tx_done;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rst_q <= RX_IDLE; smp_q <= '0; bit_q <= '0; rsh_q <= '0;
      idle_seen_q <= 1'b0; act_q <= 1'b0; rxd_q <= '0;
    end else begin
      rst_q <= rst_d; smp_q <= smp_d; bit_q <= bit_d; rsh_q <= rsh_d;
      idle_seen_q <= idle_seen_d; act_q <= act_d; rxd_q <= rxd_d;
    end
  end

  // transmit framing, gated by clear-to-send and the match state
  always_comb begin
    cts_ok   = !cts_n_q && (sch_q != SCH_CTS || !any_en || act_q);
    // launch on a tick so the start bit is a whole bit long
    tx_start = txen_q && txh_full_q && !tbusy_q && cts_ok && tk.tick;
    tbusy_d = tbusy_q; tsh_d = tsh_q; tsmp_d = tsmp_q; tbit_d = tbit_q;
    tx_done = 1'b0;
    if (tx_start) begin
      tbusy_d = 1'b1;
      tsh_d   = {1'b1, txh_q, 1'b0} | (12'hfff << (clen + 4'h1));
      tsmp_d  = '0; tbit_d = '0;
    end else if (tbusy_q && tk.tick) begin
      if (tsmp_q == tpb_tx - 7'h01) begin
        tsmp_d = '0;
        tsh_d  = {1'b1, tsh_q[11:1]};
        tbit_d = tbit_q + 4'h1;
        if (tbit_q == clen + 4'h1) begin
          tbusy_d = 1'b0;
          tx_done = 1'b1;
        end
      end else tsmp_d = tsmp_q + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tbusy_q <= 1'b0; tsh_q <= 12'hfff; tsmp_q <= '0; tbit_q <= '0;
    end else begin
      tbusy_q <= tbusy_d; tsh_q <= tsh_d; tsmp_q <= tsmp_d;
      tbit_q <= tbit_d;
    end
  end

  assign tx_pin = tbusy_q ? tsh_q[0] : 1'b1;

  osr_fallback_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_en && addr == OFF_CFG && wr_data[OSR_HI:OSR_LO] < OSR_MIN
    |=> osr_q == OSR_DEF) else $error("bad ratio not replaced");
  osr_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_en && addr == OFF_CFG && wr_data[OSR_HI:OSR_LO] >= OSR_MIN
    |=> osr_q == $past(wr_data[OSR_HI:OSR_LO])) else $error("ratio lost");
  rsv_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rd_en && addr == OFF_CFG |=> rd_data[RSV_HI:RSV_LO] == 4'h0)
    else $error("reserved bits not zero");
  ten_len_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ten_q |-> clen == LEN10) else $error("ten-bit length wrong");
  ticks_rx_a: assert property (@(posedge mclk) disable iff (sys_rst)
    dual_q && osr_q == 5'h03 |-> tpb_rx == 7'h08)
    else $error("dual edge count wrong");
  match_on_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_done && sch_q == SCH_ONOFF && hit1 && !hit2 |=> act_q)
    else $error("match on missed");
  match_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_done && sch_q == SCH_ONOFF && hit2 |=> !act_q)
    else $error("match off missed");
  cts_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sch_q == SCH_CTS && any_en && !act_q |-> !tx_start)
    else $error("send not gated");
  addr_wake_a: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_done && sch_q == SCH_ADDR && any_en && mark && !act_q && !hit1 && !hit2
    |=> !act_q ##0 !stat_q[S_RXF] || $past(stat_q[S_RXF]))
    else $error("address mismatch woke");
  irq_level_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(stat_q[S_RXF]) && mask_q[S_RXF] |-> irq)
    else $error("irq not raised");
endmodule : ubm_core

// [core/ubm_pkg.sv]
// constants and types shared by the serial configuration block
package ubm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MOD_W  = 13;
  localparam int CHAR_W = 10;
  localparam int SMP_W  = 7;
  localparam int ST_W   = 6;
  // register offsets
  localparam logic [7:0] OFF_CFG   = 8'h00;
  localparam logic [7:0] OFF_MATCH = 8'h04;
  localparam logic [7:0] OFF_CTRL  = 8'h08;
  localparam logic [7:0] OFF_DATA  = 8'h0c;
  localparam logic [7:0] OFF_STAT  = 8'h10;
  localparam logic [7:0] OFF_MASK  = 8'h14;
  // baud_config fields
  localparam int B_MEN1 = 31;
  localparam int B_MEN2 = 30;
  localparam int B_TEN  = 29;
  localparam int OSR_HI = 28;
  localparam int OSR_LO = 24;
  localparam int RSV_HI = 23;
  localparam int RSV_LO = 20;
  localparam int SCH_HI = 19;
  localparam int SCH_LO = 18;
  localparam int B_DUAL = 17;
  localparam int MOD_HI = 12;
  // match register fields
  localparam int MV1_LO = 0;
  localparam int MV2_LO = 16;
  // control register bits
  localparam int C_TXEN = 0;
  localparam int C_RXEN = 1;
  localparam int C_NINE = 2;
  // status and mask bits
  localparam int S_RXF  = 0;
  localparam int S_M1   = 1;
  localparam int S_M2   = 2;
  localparam int S_IDLE = 3;
  localparam int S_FERR = 4;
  localparam int S_TXE  = 5;
  // reset values and limits
  localparam logic [4:0]       OSR_MIN = 5'h03;
  localparam logic [4:0]       OSR_DEF = 5'h0f;
  localparam logic [MOD_W-1:0] MOD_RST = 13'h0004;
  localparam logic [3:0]       LEN8    = 4'h8;
  localparam logic [3:0]       LEN9    = 4'h9;
  localparam logic [3:0]       LEN10   = 4'ha;
  localparam logic [3:0]       IDLE_EX = 4'h2;
  typedef enum logic [1:0] {
    SCH_ADDR  = 2'b00,
    SCH_IDLE  = 2'b01,
    SCH_ONOFF = 2'b10,
    SCH_CTS   = 2'b11
  } ubm_scheme_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } ubm_rx_t;
endpackage : ubm_pkg

// [core/ubm_tick_if.sv]
// divider settings and sample enables between the core and its divider
`timescale 1ns/1ps
interface ubm_tick_if;
  logic [12:0] modulo;
  logic        dual;
  logic        tick;
  logic        half_tick;
  modport src (input modulo, input dual, output tick, output half_tick);
  modport dst (output modulo, output dual, input tick, input half_tick);
endinterface : ubm_tick_if

// [core/ubm_baud_div.sv]
// modulo divider giving the oversample enable and its mid-period twin
`timescale 1ns/1ps
module ubm_baud_div (
  input wire logic mclk,
  input wire logic sys_rst,
  ubm_tick_if.src  tk
);
  import ubm_pkg::*;
  logic [MOD_W-1:0] cnt_q, cnt_d, mod_eff;
  logic             wrap;

  // a zero modulo behaves as one
  always_comb begin
    mod_eff = (tk.modulo == '0) ? 13'h0001 : tk.modulo;
    wrap    = (cnt_q >= mod_eff - 13'h0001);
    cnt_d   = wrap ? '0 : cnt_q + 13'h0001;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) cnt_q <= '0;
    else         cnt_q <= cnt_d;
  end

  // rising-edge tick and, in dual mode with a modulo above one, the falling-edge tick
  assign tk.tick      = wrap;
  assign tk.half_tick = tk.dual && (mod_eff > 13'h0001) &&
                        (cnt_q == (mod_eff >> 1) - 13'h0001);

  no_half_single_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !tk.dual |-> !tk.half_tick) else $error("half tick in single mode");
  // a tick restarts the count, so with modulo two the next comes two later
  tick_period_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tk.tick && tk.modulo == 13'h0002 ##1 tk.modulo == 13'h0002
    |-> !tk.tick ##1 (tk.tick || tk.modulo != 13'h0002))
    else $error("tick period wrong");
endmodule : ubm_baud_div

// [bench/ubm_remote_node.sv]
// remote serial node model driving and sampling the serial lines
`timescale 1ns/1ps
module ubm_remote_node #(
  parameter int BIT_CYC = 8
) (
  input  wire logic mclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  // idle line rests high
  initial rx_line = 1'b1;

  // start low, data lsb first, one stop bit, each BIT_CYC clocks
  task automatic send_char(input logic [9:0] c, input int nb);
    @(posedge mclk);
    rx_line <= 1'b0;
    repeat (BIT_CYC) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= c[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CYC) @(posedge mclk);
  endtask : send_char

  // find a start bit, time it, then sample each bit centre
  task automatic recv_char(input int nb, output logic [9:0] c,
                           output int slen, output logic stp);
    int n;
    c = '0;
    slen = 0;
    n = 0;
    while (tx_line !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (tx_line === 1'b0 && slen < 200) begin
      @(posedge mclk);
      #1;
      slen++;
    end
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      c[i] = tx_line;
      repeat (BIT_CYC) @(posedge mclk);
    end
    stp = tx_line;
  endtask : recv_char
endmodule : ubm_remote_node

// [bench/uart_baud_match_config_tb_top.sv]
// testbench for the configuration word and its effect on framing
`timescale 1ns/1ps
module uart_baud_match_config_tb_top;
  import ubm_pkg::*;
  localparam logic [4:0]  OSR_SET = 5'h03;
  localparam logic [12:0] MOD_SET = 13'h0002;
  localparam int          BIT_CYC = (int'(OSR_SET) + 1) * int'(MOD_SET);
  localparam logic [31:0] CFG     = {3'b000, OSR_SET, 4'h0, 2'b00, 1'b1,
                                     4'h0, MOD_SET};
  logic        mclk, sys_rst, wr_en, rd_en, cts_n_pin, rx_pin, tx_pin, irq;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, v, e;
  logic [9:0]  c;
  logic        stp;
  int          bad_count, samples_checked, sl;

  ubm_core i_ubm_core (
    .mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin),
    .cts_n_pin(cts_n_pin), .tx_pin(tx_pin), .irq(irq)
  );
  ubm_remote_node #(.BIT_CYC(BIT_CYC)) i_ubm_remote_node (
    .mclk(mclk), .tx_line(tx_pin), .rx_line(rx_pin)
  );

  // free running clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // remote sends a char; status bits 2:0 and delivered data checked
  task automatic rx_one(input logic [9:0] d, input int nb,
                        input logic [2:0] s);
    logic [31:0] r;
    i_ubm_remote_node.send_char(d, nb);
    repeat (BIT_CYC) @(posedge mclk);
    rd(OFF_STAT, r);
    chk(r & 32'h7, {29'h0, s});
    wr(OFF_STAT, 32'h3f);
    if (s[0]) begin
      rd(OFF_DATA, r);
      chk(r, {22'h0, d});
    end
  endtask : rx_one

  // write a char and check what the remote receives
  task automatic tx_one(input logic [9:0] d, input int nb);
    fork
      wr(OFF_DATA, {22'h0, d});
      i_ubm_remote_node.recv_char(nb, c, sl, stp);
    join
    chk({22'h0, c}, {22'h0, d});
    chk(sl, BIT_CYC);
    chk({31'h0, stp}, 32'h1);
  endtask : tx_one

  // transmit line must stay idle for n cycles
  task automatic watch_idle(input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      if (tx_pin !== 1'b1) lows++;
    end
    chk(lows, 0);
  endtask : watch_idle

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // hang guard, far beyond the expected run of a few thousand cycles
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end

  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    cts_n_pin = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset value, reserved bits, every oversampling and scheme code
    rd(OFF_CFG, v);
    chk(v, 32'h0f000004);
    wr(OFF_CFG, 32'hffffffff);
    rd(OFF_CFG, v);
    chk(v, 32'hff0e1fff);
    for (int i = 0; i < 32; i++) begin
      wr(OFF_CFG, {3'b000, 5'(i), 4'hf, 2'(i), 18'h0});
      rd(OFF_CFG, v);
      e = {3'b000, (i < 3) ? OSR_DEF : 5'(i), 4'h0, 2'(i), 18'h0};
      chk(v, e);
    end
    wr(8'h40, 32'h12345678);
    rd(8'h40, v);
    chk(v, 32'h0);
    $display("test registers done");
    // 4x oversampling needs dual edge; set while both directions off
    wr(OFF_CFG, CFG);
    wr(OFF_MASK, 32'h1);
    wr(OFF_CTRL, 32'h3);
    i_ubm_remote_node.send_char(10'h05a, 8);
    repeat (BIT_CYC) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_STAT, 32'h3f);
    rd(OFF_STAT, v);
    chk(v & 32'h1, 32'h0);
    rd(OFF_DATA, v);
    chk(v, 32'h5a);
    tx_one(10'h0a5, 8);
    $display("test framing done");
    // ten-bit characters both ways, then nine-bit ones
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CFG, CFG | 32'h20000000);
    wr(OFF_CTRL, 32'h3);
    tx_one(10'h2a5, 10);
    rx_one(10'h3c3, 10, 3'b001);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CFG, CFG);
    wr(OFF_CTRL, 32'h7);
    tx_one(10'h1a5, 9);
    rx_one(10'h15a, 9, 3'b001);
    $display("test ten-bit done");
    // match on with value one, off with value two
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CFG, CFG | 32'hc0080000);
    wr(OFF_MATCH, 32'h00220011);
    wr(OFF_CTRL, 32'h3);
    rx_one(10'h033, 8, 3'b000);
    rx_one(10'h011, 8, 3'b011);
    rx_one(10'h033, 8, 3'b001);
    rx_one(10'h022, 8, 3'b101);
    rx_one(10'h044, 8, 3'b000);
    $display("test match done");
    // transmit held until a match turns the state on, then by cts
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CFG, CFG | 32'h800c0000);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_DATA, 32'h0f1);
    watch_idle(60);
    fork
      i_ubm_remote_node.send_char(10'h011, 8);
      i_ubm_remote_node.recv_char(8, c, sl, stp);
    join
    chk({22'h0, c}, 32'h0f1);
    cts_n_pin <= 1'b1;
    wr(OFF_DATA, 32'h0c3);
    watch_idle(60);
    fork
      cts_n_pin <= 1'b0;
      i_ubm_remote_node.recv_char(8, c, sl, stp);
    join
    chk({22'h0, c}, 32'h0c3);
    $display("test gating done");
    // address marks: a mismatching address turns the state off
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CFG, CFG | 32'h80000000);
    wr(OFF_MATCH, 32'h00000091);
    wr(OFF_STAT, 32'h3f);
    wr(OFF_CTRL, 32'h3);
    rx_one(10'h0a2, 8, 3'b001);
    rx_one(10'h0a2, 8, 3'b000);
    rx_one(10'h091, 8, 3'b011);
    rx_one(10'h033, 8, 3'b001);
    $display("test address done");
    // idle match: only the first char after an idle line decides
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CFG, CFG | 32'h80040000);
    wr(OFF_CTRL, 32'h3);
    repeat (100) @(posedge mclk);
    rx_one(10'h091, 8, 3'b011);
    rx_one(10'h033, 8, 3'b001);
    repeat (100) @(posedge mclk);
    rx_one(10'h044, 8, 3'b001);
    rx_one(10'h033, 8, 3'b000);
    $display("test idle done");
    finish_test();
  end
endmodule : uart_baud_match_config_tb_top
